// ===== rtl/dcm_pkg.sv
package dcm_pkg;
	// register window, byte addresses
	localparam logic [7:0] ADDR_CTRL      = 8'h28;
	localparam logic [7:0] ADDR_ADR_HIGH  = 8'h29;
	localparam logic [7:0] ADDR_ADR_MID   = 8'h2a;
	localparam logic [7:0] ADDR_ADR_LOW   = 8'h2b;
	localparam logic [7:0] ADDR_DAT_HIGH  = 8'h2c;
	localparam logic [7:0] ADDR_DAT_LOW   = 8'h2d;
	localparam logic [7:0] ADDR_MSK_HIGH  = 8'h2e;
	localparam logic [7:0] ADDR_MSK_LOW   = 8'h2f;
	// own registers: window select / arm, interrupt status, interrupt mask
	localparam logic [7:0] ADDR_DBG_CTL1  = 8'h20;
	localparam logic [7:0] ADDR_INT_STAT  = 8'h21;
	localparam logic [7:0] ADDR_INT_MASK  = 8'h22;
	// control byte fields
	localparam int CTL_ENABLE   = 0;
	localparam int CTL_RSVD     = 1;
	localparam int CTL_DIR_EN   = 2;
	localparam int CTL_DIR_VAL  = 3;
	localparam int CTL_SESS_END = 4;
	localparam int CTL_MARK     = 5;
	localparam int CTL_BIT6     = 6;
	localparam int CTL_SIZE_EN  = 7;
	// debug_control_one fields
	localparam int DC1_SEL_LO   = 0;
	localparam int DC1_ARM      = 7;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int NUM_CH = 4;
	localparam int ADR_W  = 23;
	localparam int DAT_W  = 16;

	// one cycle of the monitored cpu bus
	typedef struct packed {
		logic              valid;   // bus cycle present
		logic [ADR_W-1:0]  addr;
		logic [DAT_W-1:0]  data;
		logic              read;    // 1 read, 0 write
		logic              byte_sz; // 1 byte, 0 word
	} dcm_bus_s;

	// per-channel register set
	typedef struct packed {
		logic [7:0]        ctl;
		logic [ADR_W-1:0]  adr;
		logic [DAT_W-1:0]  dat;
		logic [DAT_W-1:0]  msk;
	} dcm_chan_s;
endpackage : dcm_pkg

// ===== rtl/dcm_comparator.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
// Operation
// R1 - channels 0,2 eight bytes; 1,3 four bytes
// R2 - two-bit selector picks window channel
// R3 - window order: control, address, data, masks
// R4 - channels 1,3 data bytes read zero, ignore writes
// R5 - reads anytime; writes dropped while armed
// R6 - software keeps control bit 1 cleared
// R7 - bit 7 enables size compare, unless marking
// R8 - bit 6 selects word or byte size
// R9 - bit 6 inverts data match sense
// R10 - data mask selects compared data bits
// R11 - bit 5 marks opcode, triggers on execute
// R12 - bit 4 match ends session, disarms
// R13 - bit 4 clear leaves ending to sequencer
// R14 - bit 2 enables direction, bit 3 picks it
// R15 - marking ignores direction bits
// R16 - bit 0 enables the channel
// R17 - address register bits compared per bus bit
// R18 - mask bit one includes data bit
// R19 - match shown in the qualifying bus cycle
module dcm_comparator
	import dcm_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                nrst,
	input  wire logic [7:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [7:0]          reg_rdata,
	input  wire dcm_bus_s            cpu_bus,
	input  wire logic [NUM_CH-1:0]   opcode_exec,
	input  wire logic                breakpoint_enable_control,
	output logic      [NUM_CH-1:0]   chan_match,
	output logic      [NUM_CH-1:0]   opcode_mark,
	output logic                     session_end,
	output logic                     break_req,
	output logic                     irq
);
	dcm_chan_s          chan_reg [NUM_CH];   // comparator register sets
	logic [7:0]         dbg_ctl1_reg;        // selector and arm bit
	logic [NUM_CH-1:0]  int_stat_reg;        // sticky match events
	logic [NUM_CH-1:0]  int_mask_reg;        // interrupt enables
	logic [NUM_CH-1:0]  marked_reg;          // pending opcode marks
	logic [1:0]         comparator_window_select;
	logic               armed;
	logic [NUM_CH-1:0]  raw_hit;             // qualified compare this cycle
	logic [NUM_CH-1:0]  trig;                // trigger (immediate or marked)
	logic               end_now;
	dcm_chan_s          win_reg;             // register set shown in the window
	logic               win_data;            // shown channel has data bytes

	// byte lanes of the compare values; the top address lane is seven bits
	localparam int BYTE_W     = 8;
	localparam int ADR_MID_LO = BYTE_W;
	localparam int ADR_HI_LO  = 2 * BYTE_W;
	localparam int ADR_HI_W   = ADR_W - ADR_HI_LO;
	localparam int DAT_HI_LO  = BYTE_W;

	assign comparator_window_select = dbg_ctl1_reg[DC1_SEL_LO +: 2];
	assign armed = dbg_ctl1_reg[DC1_ARM];

	// odd channels carry no data comparator
	function automatic logic has_data(input logic [1:0] ch);
		has_data = ~ch[0]; // see R1
	endfunction : has_data

	// true when the address falls inside the shared window
	function automatic logic in_win(input logic [7:0] a);
		in_win = (a >= ADDR_CTRL) && (a <= ADDR_MSK_LOW); // see R3
	endfunction : in_win

	// one mux for the whole read path keeps the case arms short
	assign win_reg  = chan_reg[comparator_window_select];
	// odd channels read zero here instead of relying on stale storage
	assign win_data = has_data(comparator_window_select); // see R4

	// register writes; a write while armed is simply dropped
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				chan_reg[i] <= '0;
			end
		end else if (reg_wr && !armed && in_win(reg_addr)) begin // see R5
			unique case (reg_addr)
				ADDR_CTRL:     chan_reg[comparator_window_select].ctl <= reg_wdata; // see R2
				ADDR_ADR_HIGH: chan_reg[comparator_window_select].adr[ADR_HI_LO +: ADR_HI_W]
					<= reg_wdata[ADR_HI_W-1:0];
				ADDR_ADR_MID:  chan_reg[comparator_window_select].adr[ADR_MID_LO +: BYTE_W] <= reg_wdata;
				ADDR_ADR_LOW:  chan_reg[comparator_window_select].adr[BYTE_W-1:0] <= reg_wdata;
				default: begin
					// data and mask bytes exist only on even channels
					if (has_data(comparator_window_select)) begin // see R4
						unique case (reg_addr)
							ADDR_DAT_HIGH: chan_reg[comparator_window_select].dat[DAT_HI_LO +: BYTE_W] <= reg_wdata;
							ADDR_DAT_LOW:  chan_reg[comparator_window_select].dat[BYTE_W-1:0] <= reg_wdata;
							ADDR_MSK_HIGH: chan_reg[comparator_window_select].msk[DAT_HI_LO +: BYTE_W] <= reg_wdata;
							default:       chan_reg[comparator_window_select].msk[BYTE_W-1:0] <= reg_wdata;
						endcase
					end
				end
			endcase
		end
	end

	// debug control one: selector writable anytime, arm cleared by session end
	// a write in the ending cycle loses to the disarm, so the end always sticks
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			dbg_ctl1_reg <= RST_BYTE;
		end else if (end_now) begin
			dbg_ctl1_reg[DC1_ARM] <= 1'b0; // see R12
		end else if (reg_wr && reg_addr == ADDR_DBG_CTL1) begin
			dbg_ctl1_reg <= reg_wdata;
		end
	end

	// read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= RST_BYTE;
		end else if (!reg_rd) begin
			reg_rdata <= RST_BYTE;
		end else begin
			unique case (reg_addr)
				ADDR_CTRL:     reg_rdata <= win_reg.ctl;
				ADDR_ADR_HIGH: reg_rdata <= BYTE_W'(win_reg.adr[ADR_HI_LO +: ADR_HI_W]);
				ADDR_ADR_MID:  reg_rdata <= win_reg.adr[ADR_MID_LO +: BYTE_W];
				ADDR_ADR_LOW:  reg_rdata <= win_reg.adr[BYTE_W-1:0];
				ADDR_DAT_HIGH: reg_rdata <= win_data ? win_reg.dat[DAT_HI_LO +: BYTE_W] : RST_BYTE;
				ADDR_DAT_LOW:  reg_rdata <= win_data ? win_reg.dat[BYTE_W-1:0] : RST_BYTE;
				ADDR_MSK_HIGH: reg_rdata <= win_data ? win_reg.msk[DAT_HI_LO +: BYTE_W] : RST_BYTE;
				ADDR_MSK_LOW:  reg_rdata <= win_data ? win_reg.msk[BYTE_W-1:0] : RST_BYTE;
				ADDR_DBG_CTL1: reg_rdata <= dbg_ctl1_reg;
				ADDR_INT_STAT: reg_rdata <= BYTE_W'(int_stat_reg);
				ADDR_INT_MASK: reg_rdata <= BYTE_W'(int_mask_reg);
				default:       reg_rdata <= RST_BYTE; // unmapped reads zero
			endcase
		end
	end

	// per-channel qualification; odd channels never hold data, so their
	// data fields stay zero and are unused
	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
			logic [7:0] ctl;
			logic       adr_ok, dat_ok, size_ok, dir_ok, mark;
			assign ctl  = chan_reg[c].ctl;
			assign mark = ctl[CTL_MARK];
			assign adr_ok = (cpu_bus.addr == chan_reg[c].adr); // see R17
			if (c % 2 == 0) begin : g_data
				logic eq;
				// masked equality, optionally inverted
				assign eq = ((cpu_bus.data ^ chan_reg[c].dat) & chan_reg[c].msk) == '0; // see R10, R18
				assign dat_ok  = mark | (eq ^ ctl[CTL_BIT6]); // see R9
				assign size_ok = 1'b1;
			end else begin : g_size
				assign dat_ok  = 1'b1;
				assign size_ok = mark | ~ctl[CTL_SIZE_EN] // see R7
					| (cpu_bus.byte_sz == ctl[CTL_BIT6]); // see R8
			end
			// direction ignored when marking or disabled
			assign dir_ok = mark | ~ctl[CTL_DIR_EN] // see R15
				| (cpu_bus.read == ctl[CTL_DIR_VAL]); // see R14
			assign raw_hit[c] = cpu_bus.valid & ctl[CTL_ENABLE] // see R16
				& adr_ok & dat_ok & size_ok & dir_ok; // see R19
			assign chan_match[c]  = raw_hit[c] & ~mark; // see R11
			assign opcode_mark[c] = raw_hit[c] & mark;
			// marked opcode fires when it reaches execution
			assign trig[c] = chan_match[c] | (marked_reg[c] & opcode_exec[c]); // see R11
		end
	endgenerate

	// pending marks, set wins over the consuming execute
	// a new mark in the execute cycle belongs to a later opcode, so dropping
	// it there would lose a trigger
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			marked_reg <= '0;
		end else begin
			marked_reg <= (marked_reg & ~opcode_exec) | opcode_mark;
		end
	end

	// session end only for channels with the end bit; others go to sequencer
	// gated by the arm bit so a stray match after the session stays harmless
	always_comb begin
		end_now = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			end_now = end_now | (trig[i] & chan_reg[i].ctl[CTL_SESS_END]); // see R12, R13
		end
		end_now = end_now & armed;
	end
	assign session_end = end_now;
	assign break_req   = end_now & breakpoint_enable_control; // see R12

	// sticky status, write one clears, a new event wins
	// a trigger in the clearing cycle survives, so no event is ever lost
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			int_stat_reg <= '0;
		end else begin
			int_stat_reg <= (int_stat_reg
				& ~((reg_wr && reg_addr == ADDR_INT_STAT) ? reg_wdata[NUM_CH-1:0]
				: {NUM_CH{1'b0}})) | trig;
		end
	end

	// interrupt mask
	// masking gates only the interrupt line, never the status bits
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			int_mask_reg <= '0;
		end else if (reg_wr && reg_addr == ADDR_INT_MASK) begin
			int_mask_reg <= reg_wdata[NUM_CH-1:0];
		end
	end
	assign irq = |(int_stat_reg & int_mask_reg);

	// a window write while armed leaves every register set unchanged
	property p_armed_write_dropped;
		@(posedge core_clk) disable iff (!nrst)
		(reg_wr && armed && in_win(reg_addr))
		|=> ($stable(chan_reg[0]) && $stable(chan_reg[1])
			&& $stable(chan_reg[2]) && $stable(chan_reg[3]));
	endproperty
	a_armed_write_dropped: assert property (p_armed_write_dropped) // see R5
		else $error("control changed while armed");

	// odd channel data reads zero
	property p_odd_data_zero;
		@(posedge core_clk) disable iff (!nrst)
		(reg_rd && comparator_window_select[0] && reg_addr >= ADDR_DAT_HIGH
			&& reg_addr <= ADDR_MSK_LOW) |=> (reg_rdata == 8'h00);
	endproperty
	a_odd_data_zero: assert property (p_odd_data_zero) // see R4
		else $error("odd channel data byte not zero");

	// disabled channel never matches
	property p_disabled_quiet;
		@(posedge core_clk) disable iff (!nrst)
		!chan_reg[1].ctl[CTL_ENABLE] |-> !raw_hit[1];
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet) // see R16
		else $error("disabled channel matched");

	// marking suppresses immediate match
	property p_mark_no_match;
		@(posedge core_clk) disable iff (!nrst)
		chan_reg[0].ctl[CTL_MARK] |-> !chan_match[0];
	endproperty
	a_mark_no_match: assert property (p_mark_no_match) // see R11
		else $error("marked channel matched directly");

	// wrong direction gives no match
	property p_dir;
		@(posedge core_clk) disable iff (!nrst)
		(chan_match[0] && chan_reg[0].ctl[CTL_DIR_EN])
		|-> (cpu_bus.read == chan_reg[0].ctl[CTL_DIR_VAL]);
	endproperty
	a_dir: assert property (p_dir) // see R14
		else $error("direction mismatch matched");

	// match implies address equality
	property p_addr;
		@(posedge core_clk) disable iff (!nrst)
		chan_match[1] |-> (cpu_bus.addr == chan_reg[1].adr);
	endproperty
	a_addr: assert property (p_addr) // see R17
		else $error("match without address equality");

	// session end disarms on the next edge
	property p_disarm;
		@(posedge core_clk) disable iff (!nrst)
		session_end |=> !armed;
	endproperty
	a_disarm: assert property (p_disarm) // see R12
		else $error("not disarmed after session end");

	// size compare honoured on channel 1
	property p_size;
		@(posedge core_clk) disable iff (!nrst)
		(chan_match[1] && chan_reg[1].ctl[CTL_SIZE_EN])
		|-> (cpu_bus.byte_sz == chan_reg[1].ctl[CTL_BIT6]);
	endproperty
	a_size: assert property (p_size) // see R8
		else $error("size mismatch matched");

	// no end bit on any channel, no session end at all
	property p_no_end;
		@(posedge core_clk) disable iff (!nrst)
		(chan_reg[0].ctl[CTL_SESS_END] == 1'b0 && chan_reg[1].ctl[CTL_SESS_END] == 1'b0
			&& chan_reg[2].ctl[CTL_SESS_END] == 1'b0 && chan_reg[3].ctl[CTL_SESS_END] == 1'b0)
		|-> !session_end;
	endproperty
	a_no_end: assert property (p_no_end) // see R13
		else $error("session ended without end bit");

	// the shown channel takes a window write
	property p_win_write;
		@(posedge core_clk) disable iff (!nrst)
		(reg_wr && !armed && reg_addr == ADDR_CTRL && comparator_window_select == 2'h2)
		|=> (chan_reg[2].ctl == $past(reg_wdata));
	endproperty
	a_win_write: assert property (p_win_write) // see R2
		else $error("selected control byte not written");

	// a window write to channel 2 leaves hidden channel 0 alone
	property p_win_others;
		@(posedge core_clk) disable iff (!nrst)
		(reg_wr && !armed && reg_addr == ADDR_CTRL && comparator_window_select == 2'h2)
		|=> $stable(chan_reg[0].ctl);
	endproperty
	a_win_others: assert property (p_win_others) // see R2
		else $error("hidden control byte written");

	// the control byte sits at the lowest window address
	property p_ctl_read;
		@(posedge core_clk) disable iff (!nrst)
		(reg_rd && reg_addr == ADDR_CTRL && comparator_window_select == 2'h0)
		|=> (reg_rdata == $past(chan_reg[0].ctl));
	endproperty
	a_ctl_read: assert property (p_ctl_read) // see R3
		else $error("control byte read back wrong");

	// read data stand one cycle only, then return to zero
	property p_rdata_idle;
		@(posedge core_clk) disable iff (!nrst)
		!reg_rd |=> (reg_rdata == RST_BYTE);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) // see R3
		else $error("read data without a read");

	// odd channel data and mask writes change nothing
	property p_odd_write_ignored;
		@(posedge core_clk) disable iff (!nrst)
		(reg_wr && comparator_window_select == 2'h1
			&& reg_addr >= ADDR_DAT_HIGH && reg_addr <= ADDR_MSK_LOW)
		|=> ($stable(chan_reg[1].dat) && $stable(chan_reg[1].msk));
	endproperty
	a_odd_write_ignored: assert property (p_odd_write_ignored) // see R4
		else $error("odd channel data byte written");

	// a mark is held until its opcode executes
	property p_mark_pending;
		@(posedge core_clk) disable iff (!nrst)
		opcode_mark[0] |=> marked_reg[0];
	endproperty
	a_mark_pending: assert property (p_mark_pending) // see R11
		else $error("opcode mark not held");

	// an executed mark records a trigger
	property p_mark_trigger;
		@(posedge core_clk) disable iff (!nrst)
		(marked_reg[0] && opcode_exec[0]) |=> int_stat_reg[0];
	endproperty
	a_mark_trigger: assert property (p_mark_trigger) // see R11
		else $error("executed mark gave no trigger");

	// an immediate match is recorded on the next edge
	property p_match_status;
		@(posedge core_clk) disable iff (!nrst)
		chan_match[0] |=> int_stat_reg[0];
	endproperty
	a_match_status: assert property (p_match_status) // see R19
		else $error("match not recorded");

	// a breakpoint needs the enable, the arm and a session end
	property p_break;
		@(posedge core_clk) disable iff (!nrst)
		break_req |-> (session_end && breakpoint_enable_control && armed);
	endproperty
	a_break: assert property (p_break) // see R12
		else $error("breakpoint without session end");
endmodule : dcm_comparator

// ===== test/dcm_cpu_model.sv
`timescale 1ns/100ps
// stand-in for the instruction queue behind the comparator: it keeps the
// channels whose opcode was marked and reports them as executed when told
module dcm_cpu_model
	import dcm_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire logic              exec_en,     // queue moves marked opcodes on
	input  wire logic [NUM_CH-1:0] opcode_mark, // marks seen on the comparator
	output logic      [NUM_CH-1:0] opcode_exec  // one-cycle pulse per executed mark
);
	logic [NUM_CH-1:0] pend_reg; // marks still waiting in the queue
	// a mark executes once only, so it leaves the queue as it is reported
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			pend_reg    <= '0;
			opcode_exec <= '0;
		end else begin
			opcode_exec <= exec_en ? pend_reg : '0;
			pend_reg    <= exec_en ? opcode_mark : (pend_reg | opcode_mark);
		end
	end
endmodule : dcm_cpu_model

// ===== test/dcm_comparator_test.sv
`timescale 1ns/100ps
// bench: register calls over the plain port, bus cycles on the cpu side
module dcm_comparator_test;
	import dcm_pkg::*;
	logic              core_clk, nrst, reg_wr, reg_rd, bkpt, exec_en;
	logic [7:0]        reg_addr, reg_wdata, reg_rdata;
	dcm_bus_s          cpu_bus;
	logic [NUM_CH-1:0] opcode_exec, chan_match, opcode_mark, m_match, m_mark;
	logic              session_end, break_req, irq, m_end, m_brk;
	int                bad_count, tests_run, cyc;
	dcm_comparator dcm_comparator_inst (.core_clk(core_clk), .nrst(nrst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_bus(cpu_bus),
		.opcode_exec(opcode_exec), .breakpoint_enable_control(bkpt),
		.chan_match(chan_match), .opcode_mark(opcode_mark),
		.session_end(session_end), .break_req(break_req), .irq(irq));
	dcm_cpu_model dcm_cpu_model_inst (.core_clk(core_clk), .nrst(nrst),
		.exec_en(exec_en), .opcode_mark(opcode_mark), .opcode_exec(opcode_exec));
	// 50 ns clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		@(negedge core_clk);
		chk(reg_rdata, exp);
	endtask : rd
	// one cpu bus cycle; the combinational answers are caught mid-cycle
	task automatic bus(input logic [22:0] a, input logic [15:0] d, input logic r, b);
		@(posedge core_clk);
		cpu_bus <= '{1'b1, a, d, r, b};
		@(negedge core_clk);
		m_match = chan_match;
		m_mark  = opcode_mark;
		m_end   = session_end;
		m_brk   = break_req;
		@(posedge core_clk);
		cpu_bus.valid <= 1'b0;
	endtask : bus
	initial begin
		nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
		cpu_bus = '0; bkpt = 1'b0; exec_en = 1'b0;
		repeat (6) @(posedge core_clk);
		nrst <= 1'b1;
		rd(ADDR_CTRL, 8'h00);
		rd(8'h30, 8'h00);
		// fill every channel through the window, then read all back
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_DBG_CTL1, 8'(s));
			for (int i = 0; i < 8; i++) wr(ADDR_CTRL + 8'(i), {2'b10, 2'(s), 4'(i)});
		end
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_DBG_CTL1, 8'(s));
			for (int i = 0; i < 8; i++) rd(ADDR_CTRL + 8'(i), (s % 2 == 1 && i > 3) ? 8'h00 :
				{(i != 1), 1'b0, 2'(s), 4'(i)});
		end
		$display("window test done");
		// channel 0: address and masked data; control bit 1 always left clear
		wr(ADDR_DBG_CTL1, 8'h00);
		wr(ADDR_ADR_HIGH, 8'h12); wr(ADDR_ADR_MID, 8'h34); wr(ADDR_ADR_LOW, 8'h56);
		wr(ADDR_DAT_HIGH, 8'h12); wr(ADDR_DAT_LOW, 8'h00);
		wr(ADDR_MSK_HIGH, 8'hff); wr(ADDR_MSK_LOW, 8'h00);
		wr(ADDR_CTRL, 8'h01);
		bus(23'h12_3456, 16'h12ab, 1'b0, 1'b0); chk(m_match, 8'h01);
		bus(23'h12_3457, 16'h12ab, 1'b0, 1'b0); chk(m_match, 8'h00);
		bus(23'h12_3456, 16'h13ab, 1'b0, 1'b0); chk(m_match, 8'h00);
		wr(ADDR_CTRL, 8'h41);
		bus(23'h12_3456, 16'h13ab, 1'b0, 1'b0); chk(m_match, 8'h01);
		wr(ADDR_CTRL, 8'h05);
		bus(23'h12_3456, 16'h12ab, 1'b0, 1'b0); chk(m_match, 8'h01);
		bus(23'h12_3456, 16'h12ab, 1'b1, 1'b0); chk(m_match, 8'h00);
		wr(ADDR_CTRL, 8'h0d);
		bus(23'h12_3456, 16'h12ab, 1'b1, 1'b0); chk(m_match, 8'h01);
		wr(ADDR_CTRL, 8'h00);
		bus(23'h12_3456, 16'h12ab, 1'b0, 1'b0); chk(m_match, 8'h00);
		$display("match test done");
		// interrupt: clear sticky status, unmask channel 0, mark then execute
		wr(ADDR_INT_STAT, 8'h0f); rd(ADDR_INT_STAT, 8'h00);
		wr(ADDR_INT_MASK, 8'h01);
		@(negedge core_clk) chk(irq, 8'h00);
		wr(ADDR_CTRL, 8'h2d);
		bus(23'h12_3456, 16'h12ab, 1'b0, 1'b0); chk({m_mark, m_match}, 8'h10);
		@(negedge core_clk) chk(irq, 8'h00);
		@(posedge core_clk) exec_en <= 1'b1;
		@(posedge core_clk) exec_en <= 1'b0;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk) chk(irq, 8'h01);
		rd(ADDR_INT_STAT, 8'h01);
		wr(ADDR_INT_STAT, 8'h01);
		@(negedge core_clk) chk(irq, 8'h00);
		$display("interrupt test done");
		// channel 1: access size
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_DBG_CTL1, 8'h01);
		wr(ADDR_ADR_HIGH, 8'h12); wr(ADDR_ADR_MID, 8'h34); wr(ADDR_ADR_LOW, 8'h56);
		wr(ADDR_CTRL, 8'h81);
		bus(23'h12_3456, 16'h0000, 1'b0, 1'b1); chk(m_match, 8'h00);
		bus(23'h12_3456, 16'h0000, 1'b0, 1'b0); chk(m_match, 8'h02);
		wr(ADDR_CTRL, 8'hc1);
		bus(23'h12_3456, 16'h0000, 1'b0, 1'b1); chk(m_match, 8'h02);
		wr(ADDR_CTRL, 8'h41);
		bus(23'h12_3456, 16'h0000, 1'b0, 1'b0); chk(m_match, 8'h02);
		$display("size test done");
		// armed: writes dropped, session end only from the channel with bit 4
		wr(ADDR_CTRL, 8'h01); wr(ADDR_ADR_LOW, 8'h57);
		wr(ADDR_DBG_CTL1, 8'h00); wr(ADDR_CTRL, 8'h11);
		bkpt <= 1'b1;
		wr(ADDR_DBG_CTL1, 8'h80);
		wr(ADDR_CTRL, 8'h00); rd(ADDR_CTRL, 8'h11);
		bus(23'h12_3457, 16'h0000, 1'b0, 1'b0); chk({m_brk, m_end, m_match}, 8'h02);
		bus(23'h12_3456, 16'h1200, 1'b0, 1'b0); chk({m_brk, m_end, m_match}, 8'h31);
		rd(ADDR_DBG_CTL1, 8'h00);
		$display("session test done");
		end_sim();
	end
endmodule : dcm_comparator_test
